/* File: src/lke_layering_engine.v */
`timescale 1ns/1ps
`default_nettype none
`include "lke_map.vh"

module lke_layering_engine (
    input wire clk,
    input wire resetn,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrEn,
    output reg [7:0] regRdData_q,
    input wire [4:0] olutIndex,
    input wire [23:0] olutData,
    input wire olutWrEn,
    input wire inValid,
    output reg inReady_q,
    input wire [23:0] pixelPort,
    input wire [23:0] compositeBus,
    input wire [4:0] overlaySelect,
    input wire hardKey,
    input wire activeVideo,
    output reg outValid_q,
    input wire outReady,
    output reg [23:0] outData_q
);

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    reg [7:0] softKeyEnable_q, overlayBlend_q, softKeyFlip_q, keyingLayer_q;
    reg [7:0] yUpper_q, yLower_q, cbUpper_q, cbLower_q, crUpper_q, crLower_q, regRdData_d;

    // Overlay colours, entries 0 and 16 never selected as colours
    reg [23:0] overlayColourTable [0:31];

    // Input stage
    reg valid1_q, key1_q, active1_q;
    reg [23:0] pix1_q, comp1_q;
    reg [4:0] sel1_q;

    // Blend state
    reg [3:0] olCoef_q, olCoef_d, keyCoef_q, keyCoef_d;
    reg [4:0] lastSel_q, lastSel_d;

    // Output buffer
    reg [1:0] cnt_q, cnt_d;
    reg [23:0] spare_q;
    reg push, pop, accept;

    // Datapath
    wire hwKeyEnable, blankPass, yMatch, cbMatch, crMatch, dataKey;
    wire [1:0] layerOrder, blendProfile;
    reg effKey;
    reg [23:0] olTarget, bg, other, stageA, mixed, halfVid;

    ////////////////////////////////////////////////////////////////////////
    // Next coefficient on a ramp toward 0 or 8
    function [3:0] rampStep;
        input [3:0] k;
        input up;
        input [1:0] prof;
        begin
            if (prof == `LKE_PROFILE_FIVE)
            begin
                case (k)
                    `LKE_COEF_ZERO: rampStep = up ? `LKE_COEF_EIGHTH : `LKE_COEF_ZERO;
                    `LKE_COEF_EIGHTH: rampStep = up ? `LKE_COEF_HALF : `LKE_COEF_ZERO;
                    `LKE_COEF_HALF: rampStep = up ? `LKE_COEF_SEVEN : `LKE_COEF_EIGHTH;
                    `LKE_COEF_SEVEN: rampStep = up ? `LKE_COEF_FULL : `LKE_COEF_HALF;
                    default: rampStep = up ? `LKE_COEF_FULL : `LKE_COEF_SEVEN;
                endcase
            end
            else if (prof == `LKE_PROFILE_THREE)
            begin
                // Coefficients other than 0 and 8 left by a profile change snap to 0 or 8
                if (k == `LKE_COEF_ZERO)
                    rampStep = up ? `LKE_COEF_HALF : `LKE_COEF_ZERO;
                else if (k == `LKE_COEF_FULL)
                    rampStep = up ? `LKE_COEF_FULL : `LKE_COEF_HALF;
                else
                    rampStep = up ? `LKE_COEF_FULL : `LKE_COEF_ZERO;
            end
            else
                rampStep = up ? `LKE_COEF_FULL : `LKE_COEF_ZERO;
        end
    endfunction

    // Blend one channel a*(8-k)/8 + b*k/8
    function [7:0] mix8;
        input [7:0] a;
        input [7:0] b;
        input [3:0] k;
        reg [11:0] sum;
        begin
            sum = a * (4'h8 - k) + b * k;
            mix8 = sum[10:3];
        end
    endfunction

    // Blend all three channels
    function [23:0] mix24;
        input [23:0] a;
        input [23:0] b;
        input [3:0] k;
        begin
            mix24 = {mix8(a[23:16], b[23:16], k), mix8(a[15:8], b[15:8], k),
                mix8(a[7:0], b[7:0], k)};
        end
    endfunction

    // Halve luma, halve chroma about its zero level
    function [23:0] half24;
        input [23:0] v;
        begin
            half24 = {1'b0, v[23:17], {1'b0, v[15:9]} + (`LKE_CHROMA_MID >> 1),
                {1'b0, v[7:1]} + (`LKE_CHROMA_MID >> 1)};
        end
    endfunction

    // Saturating add of colour and half video, chroma taken about zero
    function [7:0] addSat;
        input [7:0] c;
        input [7:0] h;
        input chroma;
        reg [9:0] s;
        begin
            if (chroma)
                s = {2'b00, c} + {2'b00, h} - {2'b00, `LKE_CHROMA_MID};
            else
                s = {2'b00, c} + {2'b00, h};
            if (s[9])
                addSat = 8'h00;
            else if (s[8])
                addSat = 8'hff;
            else
                addSat = s[7:0];
        end
    endfunction

    // Channel window test; a disabled channel always matches
    function inWindow;
        input [7:0] v;
        input [7:0] lower;
        input [7:0] upper;
        input dis;
        begin
            inWindow = dis | ((v > lower) && (v <= upper));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register writes and reads
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            softKeyEnable_q <= `LKE_REG_RESET;
            overlayBlend_q <= `LKE_REG_RESET;
            softKeyFlip_q <= `LKE_REG_RESET;
            keyingLayer_q <= `LKE_REG_RESET;
            yUpper_q <= `LKE_REG_RESET;
            yLower_q <= `LKE_REG_RESET;
            cbUpper_q <= `LKE_REG_RESET;
            cbLower_q <= `LKE_REG_RESET;
            crUpper_q <= `LKE_REG_RESET;
            crLower_q <= `LKE_REG_RESET;
            regRdData_q <= 8'h00;
        end
        else
        begin
            regRdData_q <= regRdData_d;
            if (regWrEn)
            begin
                case (regAddr)
                    `LKE_ADDR_SOFT_KEY_ENABLE: softKeyEnable_q <= regWrData;
                    `LKE_ADDR_OVERLAY_BLEND: overlayBlend_q <= regWrData;
                    `LKE_ADDR_SOFT_KEY_FLIP: softKeyFlip_q <= regWrData;
                    `LKE_ADDR_KEYING_LAYER: keyingLayer_q <= regWrData;
                    `LKE_ADDR_Y_UPPER: yUpper_q <= regWrData;
                    `LKE_ADDR_Y_LOWER: yLower_q <= regWrData;
                    `LKE_ADDR_CB_UPPER: cbUpper_q <= regWrData;
                    `LKE_ADDR_CB_LOWER: cbLower_q <= regWrData;
                    `LKE_ADDR_CR_UPPER: crUpper_q <= regWrData;
                    `LKE_ADDR_CR_LOWER: crLower_q <= regWrData;
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        case (regAddr)
            `LKE_ADDR_SOFT_KEY_ENABLE: regRdData_d = softKeyEnable_q;
            `LKE_ADDR_OVERLAY_BLEND: regRdData_d = overlayBlend_q;
            `LKE_ADDR_SOFT_KEY_FLIP: regRdData_d = softKeyFlip_q;
            `LKE_ADDR_KEYING_LAYER: regRdData_d = keyingLayer_q;
            `LKE_ADDR_Y_UPPER: regRdData_d = yUpper_q;
            `LKE_ADDR_Y_LOWER: regRdData_d = yLower_q;
            `LKE_ADDR_CB_UPPER: regRdData_d = cbUpper_q;
            `LKE_ADDR_CB_LOWER: regRdData_d = cbLower_q;
            `LKE_ADDR_CR_UPPER: regRdData_d = crUpper_q;
            `LKE_ADDR_CR_LOWER: regRdData_d = crLower_q;
            default: regRdData_d = 8'h00;
        endcase
    end

    // Colour table, no reset so it maps to plain memory
    always @(posedge clk)
    begin
        if (olutWrEn)
            overlayColourTable[olutIndex] <= olutData;
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    assign hwKeyEnable = keyingLayer_q[`LKE_BIT_HW_KEY_ENABLE];
    assign blankPass = keyingLayer_q[`LKE_BIT_BLANK_PASS];
    assign layerOrder = keyingLayer_q[`LKE_LAYER_HI:`LKE_LAYER_LO];
    assign blendProfile = overlayBlend_q[`LKE_BLEND_HI:`LKE_BLEND_LO];

    // Data key from the pixel in stage one
    assign yMatch = inWindow(pix1_q[23:16], yLower_q, yUpper_q,
        keyingLayer_q[`LKE_BIT_Y_DISABLE]);
    assign cbMatch = inWindow(pix1_q[15:8], cbLower_q, cbUpper_q,
        keyingLayer_q[`LKE_BIT_CB_DISABLE]);
    assign crMatch = inWindow(pix1_q[7:0], crLower_q, crUpper_q,
        keyingLayer_q[`LKE_BIT_CR_DISABLE]);
    assign dataKey = yMatch & cbMatch & crMatch;

    ////////////////////////////////////////////////////////////////////////
    // Buffer handshake; one word may still be in stage one, so ready
    // reserves room for it and a receiver stall loses nothing
    always @*
    begin
        accept = inValid & inReady_q;
        push = valid1_q;
        pop = outValid_q & outReady;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // Stage one captures pixel, composite, select and key together
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            valid1_q <= 1'b0;
            pix1_q <= 24'h000000;
            comp1_q <= 24'h000000;
            sel1_q <= 5'h00;
            key1_q <= 1'b0;
            active1_q <= 1'b0;
            inReady_q <= 1'b0;
        end
        else
        begin
            valid1_q <= accept;
            inReady_q <= ({1'b0, cnt_d} + {2'b00, accept}) < 3'h2;
            if (accept)
            begin
                pix1_q <= pixelPort;
                comp1_q <= compositeBus;
                sel1_q <= overlaySelect;
                key1_q <= hardKey;
                active1_q <= activeVideo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective key; blanking forces the pixel-port path
    always @*
    begin
        effKey = hwKeyEnable & (key1_q | dataKey);
        if (!active1_q && !blankPass)
            effKey = layerOrder[1];
    end

    // Ramps advance once per pixel moved into the buffer
    always @*
    begin
        keyCoef_d = keyCoef_q;
        olCoef_d = olCoef_q;
        lastSel_d = lastSel_q;
        if (push)
        begin
            keyCoef_d = rampStep(keyCoef_q, effKey, `LKE_PROFILE_FIVE);
            olCoef_d = rampStep(olCoef_q, sel1_q != `LKE_SEL_PASS, blendProfile);
            if (sel1_q != `LKE_SEL_PASS)
                lastSel_d = sel1_q;
        end
    end

    // Layer sources by order field
    always @*
    begin
        if (layerOrder[1])
        begin
            bg = comp1_q;
            other = pix1_q;
        end
        else
        begin
            bg = pix1_q;
            other = comp1_q;
        end
    end

    // Overlay target for the live or fading select code
    always @*
    begin
        halfVid = half24(stageA);
        if (lastSel_d == `LKE_SEL_HALF)
            olTarget = halfVid;
        else if (lastSel_d[4])
            olTarget = {addSat(overlayColourTable[lastSel_d][23:16], halfVid[23:16], 1'b0),
                addSat(overlayColourTable[lastSel_d][15:8], halfVid[15:8], 1'b1),
                addSat(overlayColourTable[lastSel_d][7:0], halfVid[7:0], 1'b1)};
        else if (lastSel_d == `LKE_SEL_PASS)
            olTarget = stageA;
        else
            olTarget = overlayColourTable[lastSel_d];
    end

    // Mixer order: overlay then key for orders 0 and 2, key then overlay
    always @*
    begin
        if (layerOrder[0])
        begin
            stageA = mix24(bg, other, keyCoef_d);
            mixed = mix24(stageA, olTarget, olCoef_d);
        end
        else
        begin
            stageA = bg;
            mixed = mix24(mix24(bg, olTarget, olCoef_d), other, keyCoef_d);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp state and two-entry output buffer
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            keyCoef_q <= `LKE_COEF_ZERO;
            olCoef_q <= `LKE_COEF_ZERO;
            lastSel_q <= `LKE_SEL_PASS;
            cnt_q <= 2'h0;
            spare_q <= 24'h000000;
            outData_q <= 24'h000000;
            outValid_q <= 1'b0;
        end
        else
        begin
            keyCoef_q <= keyCoef_d;
            olCoef_q <= olCoef_d;
            lastSel_q <= lastSel_d;
            cnt_q <= cnt_d;
            outValid_q <= cnt_d != 2'h0;
            if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
                outData_q <= mixed;
            else if (pop)
                outData_q <= spare_q;
            if (push && (cnt_q == 2'h2 || (!pop && cnt_q == 2'h1)))
                spare_q <= mixed;
        end
    end

endmodule // lke_layering_engine
`default_nettype wire

/* File: pkg/lke_map.vh */
`ifndef LKE_MAP_VH
`define LKE_MAP_VH

// Register offsets
`define LKE_ADDR_SOFT_KEY_ENABLE 8'h04
`define LKE_ADDR_OVERLAY_BLEND 8'h05
`define LKE_ADDR_SOFT_KEY_FLIP 8'h07
`define LKE_ADDR_KEYING_LAYER 8'h09
`define LKE_ADDR_Y_UPPER 8'h0a
`define LKE_ADDR_Y_LOWER 8'h0b
`define LKE_ADDR_CB_UPPER 8'h0c
`define LKE_ADDR_CB_LOWER 8'h0d
`define LKE_ADDR_CR_UPPER 8'h0e
`define LKE_ADDR_CR_LOWER 8'h0f

// Field positions
`define LKE_BIT_SOFT_KEY_ENABLE 2
`define LKE_BIT_SOFT_KEY_FLIP 6
`define LKE_BLEND_HI 3
`define LKE_BLEND_LO 2
`define LKE_BIT_HW_KEY_ENABLE 7
`define LKE_BIT_BLANK_PASS 6
`define LKE_BIT_SOFT_KEY_EXT 5
`define LKE_BIT_Y_DISABLE 4
`define LKE_BIT_CB_DISABLE 3
`define LKE_BIT_CR_DISABLE 2
`define LKE_LAYER_HI 1
`define LKE_LAYER_LO 0

// Reset value of every register
`define LKE_REG_RESET 8'h00

// Blend coefficients in eighths
`define LKE_COEF_ZERO 4'h0
`define LKE_COEF_EIGHTH 4'h1
`define LKE_COEF_HALF 4'h4
`define LKE_COEF_SEVEN 4'h7
`define LKE_COEF_FULL 4'h8

// Blend profiles
`define LKE_PROFILE_FIVE 2'h0
`define LKE_PROFILE_THREE 2'h1

// Overlay select codes
`define LKE_SEL_PASS 5'h00
`define LKE_SEL_HALF 5'h10

// Chroma zero level used when halving magnitude
`define LKE_CHROMA_MID 8'h80

`endif

/* File: verification/lke_layering_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lke_layering_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic [7:0] regRdData_q,
    input wire logic inValid,
    input wire logic inReady_q,
    input wire logic outValid_q,
    input wire logic outReady,
    input wire logic [23:0] outData_q
);
////////////////////////////////////////////////////////////////
    // Words inside: taken minus delivered
    logic [2:0] occ_q;
    logic [2:0] occ_d;
    assign occ_d = occ_q + {2'h0, inValid & inReady_q} - {2'h0, outValid_q & outReady};
    // Occupancy tracker
    always @(posedge clk or negedge resetn)
        if (!resetn)
            occ_q <= 3'h0;
        else
            occ_q <= occ_d;
////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Offsets that hold a register
    function automatic logic mapped(input logic [7:0] a);
        return (a inside {8'h04, 8'h05, 8'h07}) || (a >= 8'h09 && a <= 8'h0f);
    endfunction
    sequence sTaken;
        inValid && inReady_q;
    endsequence
    sequence sStalled;
        outValid_q && !outReady;
    endsequence
    // Write, then address held so the read port shows it
    sequence sWritten;
        regWrEn && mapped(regAddr) ##1 regAddr == $past(regAddr);
    endsequence
    AST_OCC_LIMIT: assert property (occ_q <= 3'h2)
        else $error("buffer holds more than two words");
    AST_FULL_REFUSE: assert property (occ_q == 3'h2 |-> !inReady_q)
        else $error("input offered ready while full");
    AST_EMPTY_IDLE: assert property (occ_q == 3'h0 |-> !outValid_q)
        else $error("output valid with nothing inside");
    AST_READY_DRAINED: assert property (occ_q == 3'h0 [*3] |-> inReady_q)
        else $error("input not ready while empty");
    AST_FIRST_WORD: assert property (sTaken ##0 occ_q == 3'h0 |-> ##2 outValid_q)
        else $error("word not out two edges after taken");
    AST_OUT_HOLD: assert property (sStalled |=> outValid_q && $stable(outData_q))
        else $error("stalled word changed or dropped");
    AST_UNMAPPED_ZERO: assert property (!mapped(regAddr) |=> regRdData_q == 8'h00)
        else $error("unmapped offset reads non-zero");
    AST_WRITE_BACK: assert property (sWritten |=> regRdData_q == $past(regWrData, 2))
        else $error("written value not read back");
endmodule // lke_layering_checker
////////////////////////////////////////////////////////////////
bind lke_layering_engine lke_layering_checker chk_u (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdData_q(regRdData_q), .inValid(inValid), .inReady_q(inReady_q),
    .outValid_q(outValid_q), .outReady(outReady), .outData_q(outData_q));
`default_nettype wire

/* File: verification/lke_video_source.sv */
`timescale 1ns/1ps
`default_nettype none
module lke_video_source (
    input wire logic clk,
    input wire logic inReady_q,
    output logic inValid,
    output logic [23:0] pixelPort,
    output logic [23:0] compositeBus,
    output logic [4:0] overlaySelect,
    output logic hardKey,
    output logic activeVideo,
    output logic [4:0] olutIndex,
    output logic [23:0] olutData,
    output logic olutWrEn
);
    bit timedOut;
    // Quiet lines at start
    initial
    begin
        {inValid, pixelPort, compositeBus, overlaySelect, hardKey, activeVideo} = '0;
        {olutIndex, olutData, olutWrEn} = '0;
        timedOut = 1'b0;
    end
////////////////////////////////////////////////////////////////
    // One pixel with its controls, held until taken; gap makes a slow source
    task automatic send(input logic [23:0] pix, composite_video_bus, input logic [4:0] sel,
        input logic key, act, input int gap);
        int n;
        n = 0;
        if (gap > 0)
            inValid <= 1'b0;
        repeat (gap) @(posedge clk);
        inValid <= 1'b1;
        {pixelPort, compositeBus, overlaySelect, hardKey, activeVideo} <= {pix, composite_video_bus, sel, key, act};
        @(posedge clk);
        while (!inReady_q && n < 200)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 200)
            timedOut = 1'b1;
    endtask
    // Released lines show the inverse, never a stale copy
    task automatic idle();
        inValid <= 1'b0;
        {pixelPort, compositeBus, overlaySelect} <= ~{pixelPort, compositeBus, overlaySelect};
        {hardKey, activeVideo} <= ~{hardKey, activeVideo};
    endtask
    // Colour in pixel format, luma kept within 1..254
    task automatic colour(input logic [4:0] idx, input logic [23:0] col);
        {olutIndex, olutData, olutWrEn} <= {idx, col, 1'b1};
        @(posedge clk);
        olutWrEn <= 1'b0;
        @(posedge clk);
    endtask
endmodule // lke_video_source
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, resetn, regWrEn, outReady, inValid, hardKey, activeVideo, olutWrEn;
    logic [7:0] regAddr, regWrData;
    logic [4:0] overlaySelect, olutIndex;
    logic [23:0] pixelPort, compositeBus, olutData;
    wire [7:0] regRdData_q;
    wire inReady_q, outValid_q;
    wire [23:0] outData_q;
    int fail_count, num_checks;
    logic [23:0] got[$];
    // ctrl, select, key, active, pixel, expected
    logic [62:0] rows [22] = '{
        {8'h00, 5'h00, 2'b01, 48'h40a060_40a060}, {8'h9c, 5'h00, 2'b11, 48'h40a060_c03050},
        {8'h1c, 5'h00, 2'b11, 48'h40a060_40a060}, {8'h9e, 5'h00, 2'b11, 48'h40a060_40a060},
        {8'h02, 5'h00, 2'b01, 48'h40a060_c03050}, {8'h01, 5'h01, 2'b01, 48'h40a060_508080},
        {8'h9c, 5'h01, 2'b11, 48'h40a060_c03050}, {8'h9d, 5'h01, 2'b11, 48'h40a060_508080},
        {8'h03, 5'h01, 2'b01, 48'h40a060_508080}, {8'h9f, 5'h00, 2'b11, 48'h40a060_40a060},
        {8'h00, 5'h10, 2'b01, 48'h40a060_209070}, {8'h00, 5'h11, 2'b01, 48'h40a060_709070},
        {8'h9c, 5'h00, 2'b10, 48'h40a060_40a060}, {8'hdc, 5'h00, 2'b10, 48'h40a060_c03050},
        {8'h8c, 5'h00, 2'b01, 48'h40a060_40a060}, {8'h8c, 5'h00, 2'b01, 48'h41a060_c03050},
        {8'h8c, 5'h00, 2'b01, 48'h80a060_c03050}, {8'h8c, 5'h00, 2'b01, 48'h81a060_81a060},
        {8'h80, 5'h00, 2'b01, 48'h60a060_c03050}, {8'h80, 5'h00, 2'b01, 48'h60a061_60a061},
        {8'h84, 5'h00, 2'b01, 48'h60a061_c03050}, {8'h80, 5'h00, 2'b11, 48'h40a060_c03050}};
    lke_layering_engine dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdData_q(regRdData_q),
        .olutIndex(olutIndex), .olutData(olutData), .olutWrEn(olutWrEn), .inValid(inValid),
        .inReady_q(inReady_q), .pixelPort(pixelPort), .compositeBus(compositeBus),
        .overlaySelect(overlaySelect), .hardKey(hardKey), .activeVideo(activeVideo),
        .outValid_q(outValid_q), .outReady(outReady), .outData_q(outData_q));
    lke_video_source src_u (.clk(clk), .inReady_q(inReady_q), .inValid(inValid),
        .pixelPort(pixelPort), .compositeBus(compositeBus), .overlaySelect(overlaySelect),
        .hardKey(hardKey), .activeVideo(activeVideo), .olutIndex(olutIndex),
        .olutData(olutData), .olutWrEn(olutWrEn));
////////////////////////////////////////////////////////////////
    // 100 ns pixel clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Receiver collects every delivered word
    always @(posedge clk)
        if (outValid_q === 1'b1 && outReady === 1'b1)
            got.push_back(outData_q);
////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] g, e);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        if (src_u.timedOut)
            fail_count++;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bounded wait for n delivered words
    task automatic waitn(input int n);
        int k;
        k = 0;
        while (got.size() < n && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        if (got.size() < n)
        begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        {regAddr, regWrData, regWrEn} <= {a, d, 1'b1};
        @(posedge clk);
        regWrEn <= 1'b0;
        @(posedge clk);
    endtask
    // Read data shows the address one edge after it is sampled
    task automatic rd(input logic [7:0] a, e);
        regAddr <= a;
        repeat (2) @(posedge clk);
        check({16'h0, regRdData_q}, {16'h0, e});
    endtask
    // Six equal pixels, long enough for every ramp to settle
    task automatic run(input logic [7:0] ctrl, input logic [4:0] sel, input logic key, act,
        input logic [23:0] pix, composite_video_bus);
        wr(8'h09, ctrl);
        got.delete();
        for (int i = 0; i < 6; i++)
            src_u.send(pix, composite_video_bus, sel, key, act, i % 2);
        src_u.idle();
        waitn(6);
    endtask
    // Step from black video to full grey, five words compared
    task automatic ramp(input logic [7:0] ctrl, input logic [4:0] sel, input logic key,
        input logic [39:0] e);
        run(ctrl, 5'h00, 1'b0, 1'b1, 24'h000000, 24'h808080);
        got.delete();
        for (int j = 0; j < 5; j++)
            src_u.send(24'h000000, 24'h808080, sel, key, 1'b1, 0);
        src_u.idle();
        waitn(5);
        for (int j = 0; j < 5; j++)
            check(got[j], {3{e[39 - 8 * j -: 8]}});
    endtask
////////////////////////////////////////////////////////////////
    initial
    begin
        {resetn, regWrEn, regAddr, regWrData} = '0;
        outReady = 1'b1;
        fail_count = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check({22'h0, inReady_q, outValid_q}, 24'h2);
        for (int a = 4; a < 17; a++)
            rd(a[7:0], 8'h00);
        for (int a = 4; a < 17; a++)
        begin
            wr(a[7:0], 8'ha5 ^ a[7:0]);
            rd(a[7:0], (a inside {4, 5, 7} || (a > 8 && a < 16)) ? 8'ha5 ^ a[7:0] : 8'h00);
        end
        $display("test registers done");
        // Windows: Y 41..80, Cb 91..a0, Cr 51..60
        wr(8'h0a, 8'h80);
        wr(8'h0b, 8'h40);
        wr(8'h0c, 8'ha0);
        wr(8'h0d, 8'h90);
        wr(8'h0e, 8'h60);
        wr(8'h0f, 8'h50);
        wr(8'h05, 8'h00);
        src_u.colour(5'h01, 24'h508080);
        src_u.colour(5'h11, 24'h508080);
        foreach (rows[i])
        begin
            run(rows[i][62:55], rows[i][54:50], rows[i][49], rows[i][48], rows[i][47:24],
                24'hc03050);
            check(got[5], rows[i][23:0]);
        end
        $display("test layering rows done");
        ramp(8'h80, 5'h00, 1'b1, 40'h1040708080);
        src_u.colour(5'h01, 24'h808080);
        for (int p = 0; p < 4; p++)
        begin
            wr(8'h05, {4'h0, p[1:0], 2'h0});
            ramp(8'h00, 5'h01, 1'b0, p == 0 ? 40'h1040708080 : p == 1 ? 40'h4080808080 :
                40'h8080808080);
        end
        $display("test ramps done");
        // Receiver stalls: two words fill the buffer, ready drops
        outReady <= 1'b0;
        got.delete();
        src_u.send(24'h123456, 24'hc03050, 5'h00, 1'b0, 1'b1, 0);
        src_u.send(24'h654321, 24'hc03050, 5'h00, 1'b0, 1'b1, 0);
        src_u.idle();
        repeat (4) @(posedge clk);
        check({22'h0, inReady_q, outValid_q}, 24'h1);
        check(outData_q, 24'h123456);
        outReady <= 1'b1;
        waitn(2);
        check(got[0], 24'h123456);
        check(got[1], 24'h654321);
        $display("test buffer done");
        wr(8'h09, 8'hdc);
        resetn <= 1'b0;
        @(posedge clk);
        check({22'h0, inReady_q, outValid_q}, 24'h0);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h09, 8'h00);
        $display("test reset done");
        summarize();
    end
endmodule // testbench
`default_nettype wire
